// file: hw/fwh_ecc_gate.sv
module fwh_ecc_gate (
	input wire logic [fwh_pkg::DATA_W-1:0] raw, // data as read
	input wire logic [fwh_pkg::DATA_W-1:0] mask, // bits flagged by ecc
	input wire logic [fwh_pkg::ERR_W-1:0] bits, // error bit count
	output logic [fwh_pkg::DATA_W-1:0] corr, // corrected data
	output logic [fwh_pkg::ERR_W-1:0] lvl, // measured level
	output logic uncorr // beyond correction
);
	import fwh_pkg::*;
	assign corr = raw ^ mask;
	assign lvl = bits;
	assign uncorr = bits > ECC_CAP;
endmodule

// file: hw/fwh_manager.sv
module fwh_manager (
	input wire logic clock, // core clock
	input wire logic rst_b, // async reset, low
	input wire logic supply_drop, // freeze level from supply monitor
	input wire logic host_req, // host request
	input wire fwh_pkg::fwh_hcmd_e host_cmd, // host command
	input wire logic [fwh_pkg::BLK_W-1:0] host_blk, // host block
	input wire logic [fwh_pkg::DATA_W-1:0] host_wdata, // host write data
	output logic host_ready, // request can be taken
	output logic host_done, // answer pulse
	output logic host_fail, // no spare or uncorrectable
	output logic [fwh_pkg::BLK_W-1:0] host_blk_out, // block in answer
	output logic [fwh_pkg::DATA_W-1:0] host_rdata, // corrected read data
	output logic fl_cmd_valid, // flash command pulse
	output fwh_pkg::fwh_fcmd_e fl_cmd, // flash command
	output logic [fwh_pkg::BLK_W-1:0] fl_blk, // flash block
	output logic [fwh_pkg::DATA_W-1:0] fl_wdata, // flash program data
	input wire logic fl_done, // flash operation finished
	input wire logic [fwh_pkg::DATA_W-1:0] fl_rdata, // raw read data
	input wire logic [fwh_pkg::DATA_W-1:0] fl_err_mask, // ecc flip mask
	input wire logic [fwh_pkg::ERR_W-1:0] fl_err_bits, // ecc error count
	output logic frozen // freeze in force
);
	import fwh_pkg::*;

	function automatic logic [BLK_W:0] first_free(input logic [NBLK-1:0] m);
		logic [BLK_W:0] r;
		r = '0;
		for (int i = NBLK - 1; i >= 0; i--)
		begin
			if (m[i])
				r = {1'b1, BLK_W'(i)};
		end
		return r;
	endfunction

	fwh_state_e state_reg;
	fwh_state_e state_next;
	logic frz;
	logic issued_reg;
	logic step;
	logic accept;
	logic [CNT_W-1:0] cnt_reg [NBLK];
	logic [NBLK-1:0] free_reg;
	logic [NBLK-1:0] bad_reg;
	logic [BLK_W-1:0] static_ptr_reg;
	logic static_valid_reg;
	logic [BLK_W-1:0] scan_reg;
	logic [BLK_W-1:0] cur_reg;
	logic [BLK_W-1:0] tgt_reg;
	logic [DATA_W-1:0] data_reg;
	logic [BLK_W:0] ff;
	logic found;
	logic [BLK_W-1:0] ff_idx;
	logic do_swap;
	logic [DATA_W-1:0] corr_data;
	logic [ERR_W-1:0] err_lvl;
	logic uncorr;
	logic flash_state;
	logic [CNT_W-1:0] fl_cnt;
	fwh_fcmd_e cmd_sel;
	logic [BLK_W-1:0] blk_sel;

	fwh_sync3 u_drop_sync (
		.clock(clock),
		.rst_b(rst_b),
		.d(supply_drop),
		.q(frz)
	);

	// every read result is corrected and its error level measured
	fwh_ecc_gate u_ecc (
		.raw(fl_rdata),
		.mask(fl_err_mask),
		.bits(fl_err_bits),
		.corr(corr_data),
		.lvl(err_lvl),
		.uncorr(uncorr)
	);

	assign ff = first_free(free_reg & ~bad_reg);
	assign found = ff[BLK_W];
	assign ff_idx = ff[BLK_W-1:0];
	assign step = issued_reg & fl_done;
	assign accept = host_req & host_ready & ~frz;
	assign do_swap = found && cnt_reg[ff_idx] > WEAR_SWAP_LIMIT
		&& static_valid_reg && static_ptr_reg != ff_idx;
	assign flash_state = state_reg != S_IDLE && state_reg != S_RESP;
	assign fl_cnt = cnt_reg[fl_blk];

	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			S_IDLE:
				if (accept)
				begin
					unique case (host_cmd)
						H_READ: state_next = S_HRD;
						H_WRITE: state_next = S_HPG;
						H_ERASE: state_next = S_HER;
						H_ALLOC: state_next = do_swap ? S_SWP_RD : S_RESP;
					endcase
				end
			S_HRD:
				if (step)
				begin
					if (uncorr)
						state_next = S_RESP;
					else if (err_lvl > RETIRE_THR && found)
						state_next = S_RET_PG;
					else if (err_lvl >= REFRESH_THR)
						state_next = S_REF_ER;
					else
						state_next = S_RESP;
				end
			S_REF_ER: if (step) state_next = S_REF_PG;
			S_SWP_RD: if (step) state_next = S_SWP_PG;
			S_SWP_PG: if (step) state_next = S_SWP_ER;
			S_REF_PG, S_RET_PG, S_HPG, S_HER, S_SWP_ER:
				if (step)
					state_next = S_RESP;
			// answer held back until the supply is good again
			S_RESP: if (!frz) state_next = S_IDLE;
			default: state_next = S_IDLE;
		endcase
	end

	always_comb
	begin
		cmd_sel = F_PROG;
		blk_sel = cur_reg;
		unique case (state_reg)
			S_HRD, S_SWP_RD: cmd_sel = F_READ;
			S_REF_ER, S_HER, S_SWP_ER: cmd_sel = F_ERASE;
			S_RET_PG, S_SWP_PG: blk_sel = tgt_reg;
			default: cmd_sel = F_PROG;
		endcase
	end

	// state only moves on flash completion while frozen
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			state_reg <= S_IDLE;
		else
			state_reg <= state_next;
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			frozen <= 1'b0;
			host_ready <= 1'b0;
			host_done <= 1'b0;
		end
		else
		begin
			frozen <= frz;
			host_ready <= state_next == S_IDLE && !frz;
			host_done <= state_reg == S_RESP && !frz;
		end
	end

	// flash issue: nothing new starts while frozen, completions still land
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			issued_reg <= 1'b0;
			fl_cmd_valid <= 1'b0;
			fl_cmd <= F_READ;
			fl_blk <= '0;
			fl_wdata <= '0;
		end
		else
		begin
			fl_cmd_valid <= 1'b0;
			if (step)
				issued_reg <= 1'b0;
			else if (flash_state && !issued_reg && !frz)
			begin
				issued_reg <= 1'b1;
				fl_cmd_valid <= 1'b1;
				fl_cmd <= cmd_sel;
				fl_blk <= blk_sel;
				fl_wdata <= data_reg;
			end
		end
	end

	// wear table; counts are volatile, reset clears them to CNT_RST
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (int i = 0; i < NBLK; i++)
				cnt_reg[i] <= CNT_RST;
		end
		else if (step && fl_cmd == F_ERASE && fl_cnt != CNT_MAX)
			cnt_reg[fl_blk] <= fl_cnt + 16'h0001;
	end

	// job context and answer fields
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cur_reg <= '0;
			tgt_reg <= '0;
			data_reg <= '0;
			host_fail <= 1'b0;
			host_blk_out <= '0;
			host_rdata <= '0;
		end
		else if (accept)
		begin
			cur_reg <= host_blk;
			data_reg <= host_wdata;
			host_blk_out <= host_blk;
			host_fail <= 1'b0;
			if (host_cmd == H_ALLOC)
			begin
				host_fail <= !found;
				tgt_reg <= ff_idx;
				cur_reg <= do_swap ? static_ptr_reg : ff_idx;
				host_blk_out <= do_swap ? static_ptr_reg : ff_idx;
			end
		end
		else if (step && (state_reg == S_HRD || state_reg == S_SWP_RD))
		begin
			data_reg <= corr_data;
			tgt_reg <= state_reg == S_HRD ? ff_idx : tgt_reg;
			if (state_reg == S_HRD)
			begin
				host_rdata <= corr_data;
				host_fail <= uncorr;
			end
		end
		else if (step && state_reg == S_RET_PG)
			host_blk_out <= tgt_reg;
	end

	// spare pool and bad-block map
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			free_reg <= FREE_RST;
			bad_reg <= BAD_RST;
		end
		else if (accept && host_cmd == H_ALLOC && found)
			free_reg[ff_idx] <= 1'b0;
		else if (step && state_reg == S_HER)
			free_reg[cur_reg] <= 1'b1;
		else if (step && state_reg == S_RET_PG)
		begin
			free_reg[tgt_reg] <= 1'b0;
			bad_reg[cur_reg] <= 1'b1;
		end
	end

	// rolling scan keeps the least-worn used block as static pointer
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			scan_reg <= '0;
			static_ptr_reg <= '0;
			static_valid_reg <= 1'b0;
		end
		else
		begin
			scan_reg <= scan_reg + 4'h1;
			if (step && state_reg == S_SWP_ER)
			begin
				static_ptr_reg <= tgt_reg;
				static_valid_reg <= 1'b1;
			end
			else if (free_reg[static_ptr_reg] || bad_reg[static_ptr_reg])
				static_valid_reg <= 1'b0;
			else if (!free_reg[scan_reg] && !bad_reg[scan_reg]
				&& (!static_valid_reg
				|| cnt_reg[scan_reg] < cnt_reg[static_ptr_reg]))
			begin
				static_ptr_reg <= scan_reg;
				static_valid_reg <= 1'b1;
			end
		end
	end

	sequence s_swap_start;
		state_reg == S_SWP_RD;
	endsequence

	property p_thr_order;
		@(posedge clock) disable iff (!rst_b)
		THR_ORDER_OK;
	endproperty
	a_thr_order: assert property (p_thr_order)
		else $error("retire level not above refresh level");

	property p_no_issue_frozen;
		@(posedge clock) disable iff (!rst_b)
		fl_cmd_valid |-> !$past(frz);
	endproperty
	a_no_issue_frozen: assert property (p_no_issue_frozen)
		else $error("flash command issued while frozen");

	property p_host_quiet;
		@(posedge clock) disable iff (!rst_b)
		frozen |-> !host_ready && !host_done;
	endproperty
	a_host_quiet: assert property (p_host_quiet)
		else $error("host traffic while frozen");

	property p_erase_count;
		@(posedge clock) disable iff (!rst_b)
		step && fl_cmd == F_ERASE && fl_cnt != CNT_MAX
		|=> cnt_reg[$past(fl_blk)] == $past(fl_cnt) + 16'h0001;
	endproperty
	a_erase_count: assert property (p_erase_count)
		else $error("erase count not advanced");

	property p_static_drop;
		@(posedge clock) disable iff (!rst_b)
		static_valid_reg && (free_reg[static_ptr_reg] || bad_reg[static_ptr_reg])
		&& !(step && state_reg == S_SWP_ER) |=> !static_valid_reg;
	endproperty
	a_static_drop: assert property (p_static_drop)
		else $error("static pointer kept on unused block");

	property p_swap;
		@(posedge clock) disable iff (!rst_b)
		state_reg == S_IDLE && accept && host_cmd == H_ALLOC && do_swap
		|=> s_swap_start ##1 (fl_cmd_valid || frozen);
	endproperty
	a_swap: assert property (p_swap)
		else $error("over-limit block not swapped");

	property p_refresh;
		@(posedge clock) disable iff (!rst_b)
		state_reg == S_HRD && step && !uncorr && err_lvl >= REFRESH_THR
		&& !(err_lvl > RETIRE_THR && found) |=> state_reg == S_REF_ER;
	endproperty
	a_refresh: assert property (p_refresh)
		else $error("refresh not started");

	property p_retire;
		@(posedge clock) disable iff (!rst_b)
		state_reg == S_HRD && step && !uncorr && err_lvl > RETIRE_THR && found
		|=> state_reg == S_RET_PG;
	endproperty
	a_retire: assert property (p_retire)
		else $error("retirement not started");

	property p_mark_bad;
		@(posedge clock) disable iff (!rst_b)
		state_reg == S_RET_PG && step |=> bad_reg[$past(cur_reg)];
	endproperty
	a_mark_bad: assert property (p_mark_bad)
		else $error("retired block not marked bad");

	property p_corrected;
		@(posedge clock) disable iff (!rst_b)
		state_reg == S_HRD && step
		|=> data_reg == ($past(fl_rdata) ^ $past(fl_err_mask));
	endproperty
	a_corrected: assert property (p_corrected)
		else $error("read data not corrected");
endmodule

// file: hw/fwh_sync3.sv
module fwh_sync3 (
	input wire logic clock, // core clock
	input wire logic rst_b, // async reset, low
	input wire logic d, // asynchronous level
	output logic q // filtered level
);
	import fwh_pkg::*;
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s1_reg <= SYNC_RST;
			s2_reg <= SYNC_RST;
			s3_reg <= SYNC_RST;
			q <= SYNC_RST;
		end
		else
		begin
			s1_reg <= d;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			// take a change only once two late stages agree
			if (s2_reg == s3_reg)
				q <= s3_reg;
		end
	end
endmodule

// file: include/fwh_pkg.sv
package fwh_pkg;
	localparam int NBLK = 16;
	localparam int BLK_W = 4;
	localparam int CNT_W = 16;
	localparam int DATA_W = 16;
	localparam int ERR_W = 5;
	// tuning knobs; retirement must sit above refresh
	localparam logic [CNT_W-1:0] WEAR_SWAP_LIMIT = 16'h0064;
	localparam logic [ERR_W-1:0] REFRESH_THR = 5'h08;
	localparam logic [ERR_W-1:0] RETIRE_THR = 5'h0b;
	localparam logic [ERR_W-1:0] ECC_CAP = 5'h0c;
	localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
	localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
	localparam logic [NBLK-1:0] FREE_RST = 16'hffff;
	localparam logic [NBLK-1:0] BAD_RST = 16'h0000;
	localparam logic SYNC_RST = 1'b0;
	localparam bit THR_ORDER_OK = RETIRE_THR > REFRESH_THR;

	typedef enum logic [1:0]
	{
		H_READ = 2'h0,
		H_WRITE = 2'h1,
		H_ERASE = 2'h2,
		H_ALLOC = 2'h3
	} fwh_hcmd_e;

	typedef enum logic [1:0]
	{
		F_READ = 2'h0,
		F_PROG = 2'h1,
		F_ERASE = 2'h2
	} fwh_fcmd_e;

	typedef enum logic [10:0]
	{
		S_IDLE = 11'h001,
		S_HRD = 11'h002,
		S_REF_ER = 11'h004,
		S_REF_PG = 11'h008,
		S_RET_PG = 11'h010,
		S_HPG = 11'h020,
		S_HER = 11'h040,
		S_SWP_RD = 11'h080,
		S_SWP_PG = 11'h100,
		S_SWP_ER = 11'h200,
		S_RESP = 11'h400
	} fwh_state_e;
endpackage

// file: verif/fwh_flash_model.sv
module fwh_flash_model (
	input wire logic clock, // core clock
	input wire logic rst_b, // async reset, low
	input wire logic cmd_valid, // command pulse
	input wire fwh_pkg::fwh_fcmd_e cmd, // command
	input wire logic [fwh_pkg::BLK_W-1:0] blk, // block
	input wire logic [fwh_pkg::DATA_W-1:0] wdata, // program data
	input wire logic [7:0] lat, // busy cycles
	input wire logic [fwh_pkg::BLK_W-1:0] inj_blk, // weak block
	input wire logic [fwh_pkg::DATA_W-1:0] inj_mask, // flipped bits
	input wire logic [fwh_pkg::ERR_W-1:0] inj_bits, // reported count
	output logic done, // finish pulse
	output logic [fwh_pkg::DATA_W-1:0] rdata, // raw data
	output logic [fwh_pkg::DATA_W-1:0] err_mask, // ecc mask
	output logic [fwh_pkg::ERR_W-1:0] err_bits // ecc count
);
	import fwh_pkg::*;
	logic [DATA_W-1:0] mem [NBLK];
	logic [7:0] cnt_reg;
	logic busy_reg;
	logic rd_reg;
	logic [BLK_W-1:0] blk_reg;
	logic hit;
	assign hit = rd_reg && blk_reg == inj_blk;
	always_ff @(posedge clock)
	begin
		if (cmd_valid && cmd == F_PROG)
			mem[blk] <= wdata;
		else if (cmd_valid && cmd == F_ERASE)
			mem[blk] <= 16'hffff;
	end
	// lines toggle outside a done pulse so stale data is never trusted
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			busy_reg <= 1'b0;
			cnt_reg <= 8'h00;
			rd_reg <= 1'b0;
			blk_reg <= 4'h0;
			done <= 1'b0;
			rdata <= 16'h0000;
			err_mask <= 16'h0000;
			err_bits <= 5'h00;
		end
		else
		begin
			done <= 1'b0;
			rdata <= ~rdata;
			err_mask <= ~err_mask;
			err_bits <= ~err_bits;
			if (cmd_valid)
			begin
				busy_reg <= 1'b1;
				cnt_reg <= lat;
				rd_reg <= cmd == F_READ;
				blk_reg <= blk;
			end
			else if (busy_reg && cnt_reg != 8'h00)
				cnt_reg <= cnt_reg - 8'h01;
			else if (busy_reg)
			begin
				busy_reg <= 1'b0;
				done <= 1'b1;
				rdata <= mem[blk_reg] ^ (hit ? inj_mask : 16'h0000);
				err_mask <= hit ? inj_mask : 16'h0000;
				err_bits <= hit ? inj_bits : 5'h00;
			end
		end
	end
endmodule

// file: verif/tb.sv
`define CHK(nm, e, g) \
begin \
	n_compared++; \
	if ((g) !== (e)) \
	begin \
		failures++; \
		$display("FAIL %s exp %h got %h", nm, (e), (g)); \
	end \
end

module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import fwh_pkg::*;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic supply_drop = 1'b0;
	logic host_req = 1'b0;
	fwh_hcmd_e host_cmd = H_READ;
	logic [BLK_W-1:0] host_blk = 4'h0;
	logic [DATA_W-1:0] host_wdata = 16'h0000;
	logic host_ready, host_done, host_fail, fl_cmd_valid, fl_done, frozen;
	logic [BLK_W-1:0] host_blk_out, fl_blk, stat_blk, weak_blk;
	logic [DATA_W-1:0] host_rdata, fl_wdata, fl_rdata, fl_err_mask;
	logic [ERR_W-1:0] fl_err_bits;
	fwh_fcmd_e fl_cmd;
	logic [7:0] lat = 8'h02;
	logic [BLK_W-1:0] inj_blk = 4'h0;
	logic [DATA_W-1:0] inj_mask = 16'h0000;
	logic [ERR_W-1:0] inj_bits = 5'h00;
	int failures = 0;
	int n_compared = 0;
	int nops = 0;
	fwh_fcmd_e lc [4];
	logic [BLK_W-1:0] lb [4];
	logic [DATA_W-1:0] lw [4];

	always #2.5 clock = ~clock;

	fwh_manager fwh_manager_inst (.clock(clock), .rst_b(rst_b),
		.supply_drop(supply_drop), .host_req(host_req),
		.host_cmd(host_cmd), .host_blk(host_blk), .host_wdata(host_wdata),
		.host_ready(host_ready), .host_done(host_done),
		.host_fail(host_fail), .host_blk_out(host_blk_out),
		.host_rdata(host_rdata), .fl_cmd_valid(fl_cmd_valid),
		.fl_cmd(fl_cmd), .fl_blk(fl_blk), .fl_wdata(fl_wdata),
		.fl_done(fl_done), .fl_rdata(fl_rdata),
		.fl_err_mask(fl_err_mask), .fl_err_bits(fl_err_bits),
		.frozen(frozen));

	fwh_flash_model fwh_flash_model_inst (.clock(clock), .rst_b(rst_b),
		.cmd_valid(fl_cmd_valid), .cmd(fl_cmd), .blk(fl_blk),
		.wdata(fl_wdata), .lat(lat), .inj_blk(inj_blk),
		.inj_mask(inj_mask), .inj_bits(inj_bits), .done(fl_done),
		.rdata(fl_rdata), .err_mask(fl_err_mask), .err_bits(fl_err_bits));

	always @(posedge clock)
	begin
		if (fl_cmd_valid === 1'b1 && nops < 4)
		begin
			lc[nops] = fl_cmd;
			lb[nops] = fl_blk;
			lw[nops] = fl_wdata;
		end
		if (fl_cmd_valid === 1'b1)
			nops++;
		if (frozen === 1'b1)
		begin
			`CHK("flash issue", 1'b0, fl_cmd_valid)
			`CHK("host handshake", 1'b0, host_ready | host_done)
		end
	end

	function automatic logic [DATA_W-1:0] dat(input logic [BLK_W-1:0] b);
		return {12'h5a3, b};
	endfunction

	task automatic close_out;
		if (failures == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic op(input fwh_hcmd_e c, input logic [BLK_W-1:0] b,
		input logic [DATA_W-1:0] d);
		int n;
		n = 0;
		nops = 0;
		@(posedge clock);
		host_req <= 1'b1;
		host_cmd <= c;
		host_blk <= b;
		host_wdata <= d;
		do
			@(posedge clock);
		while (host_ready !== 1'b1 && ++n < 400);
		host_req <= 1'b0;
		do
			@(posedge clock);
		while (host_done !== 1'b1 && ++n < 400);
		`CHK("answer in time", 1'b1, n < 400)
	endtask

	// weakness applies to one read only; probe clears the mask and count once the read is answered
	task automatic probe(input logic [BLK_W-1:0] b,
		input logic [ERR_W-1:0] e, input logic [DATA_W-1:0] m);
		inj_blk <= b;
		inj_bits <= e;
		inj_mask <= m;
		op(H_READ, b, 16'h0000);
		inj_bits <= 5'h00;
		inj_mask <= 16'h0000;
	endtask

	task automatic t_fill;
		logic [NBLK-1:0] seen;
		seen = 16'h0000;
		for (int i = 0; i < NBLK; i++)
		begin
			op(H_ALLOC, 4'h0, 16'h0000);
			`CHK("alloc", 1'b0, host_fail)
			seen[host_blk_out] = 1'b1;
			op(H_WRITE, host_blk_out, dat(host_blk_out));
		end
		`CHK("all handed out", 16'hffff, seen)
		op(H_ALLOC, 4'h0, 16'h0000);
		`CHK("pool empty", 1'b1, host_fail)
	endtask

	task automatic t_ecc;
		`CHK("level order", 1'b1, RETIRE_THR > REFRESH_THR)
		probe(4'h3, REFRESH_THR - 5'h01, 16'h007f);
		`CHK("corrected read", dat(4'h3), host_rdata)
		`CHK("ops below level", 1, nops)
		`CHK("read fail", 1'b0, host_fail)
	endtask

	task automatic t_refresh;
		probe(4'h3, REFRESH_THR, 16'h00ff);
		`CHK("refresh read", dat(4'h3), host_rdata)
		`CHK("refresh ops", 3, nops)
		`CHK("refresh erase", {F_ERASE, 4'h3}, {lc[1], lb[1]})
		`CHK("refresh prog", {F_PROG, 4'h3}, {lc[2], lb[2]})
		`CHK("refresh data", dat(4'h3), lw[2])
	endtask

	task automatic t_uncorr;
		probe(4'h4, ECC_CAP + 5'h01, 16'h1fff);
		`CHK("uncorrectable", 1'b1, host_fail)
		`CHK("uncorr ops", 1, nops)
	endtask

	task automatic t_wear;
		for (int k = 0; k <= int'(WEAR_SWAP_LIMIT); k++)
		begin
			op(H_ERASE, 4'h5, 16'h0000);
			op(H_ALLOC, 4'h0, 16'h0000);
			if (k < int'(WEAR_SWAP_LIMIT))
				`CHK("no swap", {4'h5, 1'b1}, {host_blk_out, nops == 0})
		end
		stat_blk = lb[0];
		`CHK("swap ops", 3, nops)
		`CHK("static read", F_READ, lc[0])
		`CHK("spare prog", {F_PROG, 4'h5}, {lc[1], lb[1]})
		`CHK("swap data", dat(stat_blk), lw[1])
		`CHK("static erase", {F_ERASE, stat_blk}, {lc[2], lb[2]})
		`CHK("static given", stat_blk, host_blk_out)
	endtask

	task automatic t_retire;
		weak_blk = (stat_blk == 4'h7) ? 4'h8 : 4'h7;
		op(H_ERASE, stat_blk, 16'h0000);
		probe(weak_blk, RETIRE_THR + 5'h01, 16'h0fff);
		`CHK("retire read", dat(weak_blk), host_rdata)
		`CHK("retire ops", 2, nops)
		`CHK("retire prog", {F_PROG, stat_blk}, {lc[1], lb[1]})
		`CHK("retire data", dat(weak_blk), lw[1])
		`CHK("new block", stat_blk, host_blk_out)
		op(H_ERASE, weak_blk, 16'h0000);
		op(H_ALLOC, 4'h0, 16'h0000);
		`CHK("bad not reused", 1'b1, host_fail)
	endtask

	task automatic t_freeze;
		int n;
		n = 0;
		lat <= 8'h28;
		fork
			op(H_WRITE, stat_blk, 16'h1234);
			begin
				do
					@(posedge clock);
				while (fl_cmd_valid !== 1'b1 && ++n < 50);
				supply_drop <= 1'b1;
				repeat (8) @(posedge clock);
				`CHK("frozen", 1'b1, frozen)
				repeat (60) @(posedge clock);
				supply_drop <= 1'b0;
			end
		join
		// read lands while frozen, so the refresh steps must wait for thaw
		n = 0;
		fork
			probe(stat_blk, REFRESH_THR, 16'h0003);
			begin
				do
					@(posedge clock);
				while (fl_cmd_valid !== 1'b1 && ++n < 50);
				supply_drop <= 1'b1;
				repeat (60) @(posedge clock);
				supply_drop <= 1'b0;
			end
		join
		`CHK("thawed refresh ops", 3, nops)
		`CHK("thawed refresh read", 16'h1234, host_rdata)
		lat <= 8'h02;
		op(H_READ, stat_blk, 16'h0000);
		`CHK("program completed", 16'h1234, host_rdata)
	endtask

	initial
	begin
		repeat (6) @(posedge clock);
		rst_b <= 1'b1;
		repeat (5) @(posedge clock);
		t_fill();
		t_ecc();
		t_refresh();
		t_uncorr();
		t_wear();
		t_retire();
		t_freeze();
		close_out();
	end

	// whole run is near 2000 cycles
	initial
	begin
		#100000;
		failures++;
		close_out();
	end
endmodule
